// ---- hw/epa_align.sv ----
`timescale 1ns/1ps
`default_nettype none

module epa_align #(
  parameter int unsigned CYC_SEC  = epa_pkg::CYC_SEC,
  parameter int unsigned CYC_TICK = epa_pkg::CYC_TICK
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  // AXI4-Lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Pins and retained selection
  input  wire logic               external_second_pulse,
  input  wire logic               freq_ref_present,
  input  wire logic               nv_pps_en,
  input  wire logic               nv_f10_en,
  // Time interval measurements, same clock
  input  wire logic signed [15:0] phase_ns,
  input  wire logic               phase_valid,
  input  wire logic signed [31:0] meas_inst_src,
  input  wire logic signed [31:0] meas_inst_ref,
  input  wire logic               meas_valid,
  input  wire logic signed [15:0] antenna_cal_ns,
  // Satellite receiver
  input  wire logic [31:0]        gnss_seconds,
  input  wire logic               gnss_valid,
  // Outputs
  output logic                    vcxo_ref_ext10,
  output logic                    ten_mhz_from_vcxo,
  output logic                    freq_input_for_meas,
  output logic                    rb_freeze,
  output logic signed [15:0]      rb_ctrl,
  output logic                    jam_sync,
  output logic                    phase_step_adv,
  output logic                    phase_step_ret,
  output logic                    tick_cal,
  output logic                    tick_1k,
  output logic                    tick_sec,
  output logic                    sec_tick_ind,
  output logic [1:0]              status,
  output logic                    missing_freq_ref_warning,
  output logic                    meas_inhibit,
  output logic                    gnss_use,
  output logic signed [31:0]      reference_minus_source,
  output logic                    result_valid
);

  // Elaboration-time refusal of divider counts the logic cannot serve
  if (CYC_SEC < 4 || CYC_TICK < 2 || epa_pkg::CYC_CAL < 2) begin : g_bad_cfg
    $error("epa_align: divider counts too small");
  end

  function automatic logic [31:0] sext16(input logic signed [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [2:0] pps_sync_q;
  logic [2:0] frq_sync_q;
  logic       pps_lvl_q;
  logic       frq_lvl_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pps_sync_q <= 3'h0;
      frq_sync_q <= 3'h0;
      pps_lvl_q  <= 1'b0;
      frq_lvl_q  <= 1'b0;
    end else begin
      pps_sync_q <= {pps_sync_q[1:0], external_second_pulse};
      frq_sync_q <= {frq_sync_q[1:0], freq_ref_present};
      if (pps_sync_q[1] == pps_sync_q[2]) pps_lvl_q <= pps_sync_q[2];
      if (frq_sync_q[1] == frq_sync_q[2]) frq_lvl_q <= frq_sync_q[2];
    end
  end
  // Filtered level changes only once two stages agree
  wire ext_edge = (pps_sync_q[1] == pps_sync_q[2]) && pps_sync_q[2]
                  && !pps_lvl_q;

  // ==========================================================
  // Control registers and AXI write path
  // ==========================================================
  logic        pps_en_q, f10_en_q, pps_en_prev_q, strap_done_q;
  logic        set_arm_q, warn_q, time_valid_q;
  logic [31:0] preset_q;
  logic [7:0]  aw_addr_q;
  logic        aw_full_q, w_full_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  wire   wr_go    = aw_full_q && w_full_q && !s_axi_bvalid;
  wire   wr_ctrl  = wr_go && (aw_addr_q == epa_pkg::A_CTRL) && w_strb_q[0];
  wire   wr_stat  = wr_go && (aw_addr_q == epa_pkg::A_STATUS) && w_strb_q[0];
  wire   wr_pre   = wr_go && (aw_addr_q == epa_pkg::A_PRESET);
  wire   wr_known = (aw_addr_q == epa_pkg::A_CTRL)
                 || (aw_addr_q == epa_pkg::A_STATUS)
                 || (aw_addr_q == epa_pkg::A_PRESET);
  wire   missing   = f10_en_q && !frq_lvl_q;
  wire   pps_rise  = pps_en_q && !pps_en_prev_q;
  logic  tick_sec_w;
  wire   set_apply = tick_sec_w && set_arm_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= epa_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? epa_pkg::RESP_OKAY : epa_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Selection survives restart through the retained straps; time does not
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pps_en_q      <= 1'b0;
      f10_en_q      <= 1'b0;
      pps_en_prev_q <= 1'b0;
      strap_done_q  <= 1'b0;
      set_arm_q     <= 1'b0;
      warn_q        <= 1'b0;
      preset_q      <= 32'h0;
    end else begin
      pps_en_prev_q <= pps_en_q;
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        pps_en_q     <= nv_pps_en;
        f10_en_q     <= nv_f10_en && nv_pps_en;
      end else if (wr_ctrl) begin
        pps_en_q <= w_data_q[epa_pkg::B_PPS_EN];
        f10_en_q <= w_data_q[epa_pkg::B_F10_EN]
                    && w_data_q[epa_pkg::B_PPS_EN];
      end
      if (wr_ctrl && w_data_q[epa_pkg::B_SET] && pps_en_q) set_arm_q <= 1'b1;
      else if (set_apply) set_arm_q <= 1'b0;
      if (wr_pre) preset_q <= w_data_q;
      // Event wins over a clear in the same cycle
      if (missing) warn_q <= 1'b1;
      else if (wr_stat && w_data_q[epa_pkg::B_WARN]) warn_q <= 1'b0;
    end
  end

  // ==========================================================
  // Alignment sequencer
  // ==========================================================
  epa_pkg::epa_align_t st_q, st_d;
  wire phase_big_pos = phase_ns >= 16'(epa_pkg::TOL_NS);
  wire phase_big_neg = phase_ns <= -16'(epa_pkg::TOL_NS);

  always_comb begin
    st_d = st_q;
    case (st_q)
      epa_pkg::AL_OFF:  if (pps_rise) st_d = epa_pkg::AL_JAM;
      epa_pkg::AL_JAM:  if (ext_edge) st_d = epa_pkg::AL_MEAS;
      epa_pkg::AL_MEAS: if (phase_valid) begin
        st_d = (phase_big_pos || phase_big_neg) ? epa_pkg::AL_STEP
                                                : epa_pkg::AL_LOCK;
      end
      epa_pkg::AL_STEP: st_d = epa_pkg::AL_MEAS;
      epa_pkg::AL_LOCK: st_d = epa_pkg::AL_LOCK;
      default:          st_d = epa_pkg::AL_OFF;
    endcase
    if (!pps_en_q) st_d = epa_pkg::AL_OFF;
    else if (pps_rise) st_d = epa_pkg::AL_JAM;
  end

  logic signed [15:0] phase_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q           <= epa_pkg::AL_OFF;
      jam_sync       <= 1'b0;
      phase_step_adv <= 1'b0;
      phase_step_ret <= 1'b0;
      phase_q        <= 16'sh0;
      rb_ctrl        <= 16'sh0;
    end else begin
      st_q     <= st_d;
      jam_sync <= (st_q == epa_pkg::AL_JAM) && ext_edge && pps_en_q;
      // One 10ns step per measurement until inside the window
      phase_step_ret <= (st_q == epa_pkg::AL_MEAS) && phase_valid
                        && phase_big_pos && pps_en_q;
      phase_step_adv <= (st_q == epa_pkg::AL_MEAS) && phase_valid
                        && phase_big_neg && pps_en_q;
      if (phase_valid && tick_sec_w) phase_q <= phase_ns;
      // Slow steering only; the external frequency ref freezes it
      if ((st_q == epa_pkg::AL_LOCK) && phase_valid && tick_sec_w
          && !f10_en_q) begin
        rb_ctrl <= rb_ctrl - phase_ns;
      end
    end
  end

  // ==========================================================
  // Divider chain and seconds count
  // ==========================================================
  logic [31:0] sec_div_q;
  logic [31:0] tick_div_q;
  logic [7:0]  cal_div_q;
  logic [31:0] seconds_q;
  wire jam_now = (st_q == epa_pkg::AL_JAM) && ext_edge && pps_en_q;
  assign tick_sec_w = sec_div_q == 32'(CYC_SEC - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_div_q    <= 32'h0;
      tick_div_q   <= 32'h0;
      cal_div_q    <= 8'h0;
      seconds_q    <= 32'h0;
      tick_sec     <= 1'b0;
      tick_1k      <= 1'b0;
      tick_cal     <= 1'b0;
      sec_tick_ind <= 1'b0;
      time_valid_q <= 1'b0;
    end else begin
      if (jam_now) begin
        sec_div_q  <= 32'h0;
        tick_div_q <= 32'h0;
        cal_div_q  <= 8'h0;
      end else begin
        sec_div_q  <= tick_sec_w ? 32'h0 : sec_div_q + 32'h1;
        tick_div_q <= (tick_div_q == 32'(CYC_TICK - 1)) ? 32'h0
                                                        : tick_div_q + 32'h1;
        cal_div_q  <= (cal_div_q == 8'(epa_pkg::CYC_CAL - 1)) ? 8'h0
                                                            : cal_div_q + 8'h1;
      end
      tick_sec <= tick_sec_w && !jam_now;
      tick_1k  <= (tick_div_q == 32'(CYC_TICK - 1)) && !jam_now;
      tick_cal <= (cal_div_q == 8'(epa_pkg::CYC_CAL - 1)) && !jam_now;
      // Indicator on for the first half of each second
      if (tick_sec_w) sec_tick_ind <= 1'b1;
      else if (sec_div_q == 32'(CYC_SEC / 2)) sec_tick_ind <= 1'b0;
      if (set_apply) seconds_q <= preset_q;
      else if (tick_sec_w && !pps_en_q && gnss_valid)
        seconds_q <= gnss_seconds + 32'h1;
      else if (tick_sec_w) seconds_q <= seconds_q + 32'h1;
      if (missing) time_valid_q <= 1'b0;
      else if (set_apply) time_valid_q <= 1'b1;
      else if (!pps_en_q) time_valid_q <= gnss_valid;
    end
  end

  // ==========================================================
  // Measurement result and status
  // ==========================================================
  wire aligning = (st_q == epa_pkg::AL_JAM) || (st_q == epa_pkg::AL_MEAS)
               || (st_q == epa_pkg::AL_STEP);
  wire [1:0] status_d = missing      ? epa_pkg::ST_RED :
                        aligning     ? epa_pkg::ST_YELLOW :
                        time_valid_q ? epa_pkg::ST_GREEN
                                     : epa_pkg::ST_RED;
  wire signed [31:0] diff_w = meas_inst_src - meas_inst_ref;
  wire signed [31:0] cal_w  = pps_en_q ? 32'sh0
                                       : sext16(antenna_cal_ns);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status                 <= epa_pkg::ST_RED;
      reference_minus_source <= 32'sh0;
      result_valid           <= 1'b0;
    end else begin
      status       <= status_d;
      result_valid <= meas_valid && !missing;
      if (meas_valid && !missing) reference_minus_source <= diff_w + cal_w;
    end
  end

  assign vcxo_ref_ext10           = f10_en_q;
  assign ten_mhz_from_vcxo        = f10_en_q;
  assign freq_input_for_meas      = !f10_en_q;
  assign rb_freeze                = f10_en_q;
  assign missing_freq_ref_warning = warn_q;
  assign meas_inhibit             = missing;
  assign gnss_use                 = !pps_en_q;

  // ==========================================================
  // AXI read path
  // ==========================================================
  wire [31:0] stat_w = {27'h0, st_q == epa_pkg::AL_LOCK, missing, warn_q,
                        status};
  wire [31:0] ctrl_w = {29'h0, set_arm_q, f10_en_q, pps_en_q};
  wire [7:0]  ra     = {s_axi_araddr[7:2], 2'h0};
  wire        rd_ok  = (ra <= epa_pkg::A_RBCTRL);
  wire [31:0] rd_w   = (ra == epa_pkg::A_CTRL)    ? ctrl_w :
                       (ra == epa_pkg::A_STATUS)  ? stat_w :
                       (ra == epa_pkg::A_PRESET)  ? preset_q :
                       (ra == epa_pkg::A_SECONDS) ? seconds_q :
                       (ra == epa_pkg::A_PHASE)   ? sext16(phase_q) :
                       (ra == epa_pkg::A_RESULT)  ? reference_minus_source :
                       (ra == epa_pkg::A_RBCTRL)  ? sext16(rb_ctrl) : 32'h0;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= epa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_w : 32'h0;
      s_axi_rresp  <= rd_ok ? epa_pkg::RESP_OKAY : epa_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_f10_needs_pps;
    f10_en_q |-> pps_en_q;
  endproperty
  a_f10_needs_pps: assert property (p_f10_needs_pps)
    else $error("frequency ref selected without pulse ref");

  property p_rb_frozen;
    f10_en_q && $past(f10_en_q) |-> $stable(rb_ctrl);
  endproperty
  a_rb_frozen: assert property (p_rb_frozen)
    else $error("rubidium control moved while frozen");

  property p_jam_clears;
    jam_sync |-> sec_div_q == 32'h0 && !tick_sec;
  endproperty
  a_jam_clears: assert property (p_jam_clears)
    else $error("jam did not reset the divider");

  property p_step_ret;
    st_q == epa_pkg::AL_MEAS && phase_valid && phase_big_pos && pps_en_q
      |=> phase_step_ret && !phase_step_adv ##1 !phase_step_ret;
  endproperty
  a_step_ret: assert property (p_step_ret)
    else $error("positive offset not stepped once");

  property p_yellow;
    aligning && !missing |=> status == epa_pkg::ST_YELLOW;
  endproperty
  a_yellow: assert property (p_yellow)
    else $error("status not yellow while aligning");

  property p_set_load;
    set_apply && !missing |=> seconds_q == $past(preset_q)
      ##1 status == epa_pkg::ST_GREEN || aligning;
  endproperty
  a_set_load: assert property (p_set_load)
    else $error("manual set not applied to new second");

  property p_inhibit;
    missing |=> !result_valid ##1 status == epa_pkg::ST_RED;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("measurement not inhibited without frequency ref");

  property p_result;
    meas_valid && pps_en_q && !missing
      |=> result_valid && reference_minus_source
          == $past(meas_inst_src) - $past(meas_inst_ref);
  endproperty
  a_result: assert property (p_result)
    else $error("wrong reference minus source result");

  property p_tick_ind;
    tick_sec_w |=> sec_tick_ind [*3];
  endproperty
  a_tick_ind: assert property (p_tick_ind)
    else $error("second indicator not raised");

  c_lock: cover property (st_q == epa_pkg::AL_MEAS ##1
                          st_q == epa_pkg::AL_LOCK);
  c_step: cover property (phase_step_adv || phase_step_ret);
  c_set:  cover property (set_apply ##2 status == epa_pkg::ST_GREEN);

endmodule

`default_nettype wire

// ---- hw/epa_pkg.sv ----
package epa_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Interpolator calibration clock period
  localparam int unsigned CAL_PERIOD_NS = 200;
  localparam int unsigned CYC_CAL       = CAL_PERIOD_NS / CLK_PERIOD_NS;
  // Timekeeping tick, 1kHz
  localparam int unsigned TICK_HZ       = 1000;
  localparam int unsigned CYC_TICK      = CLK_HZ / TICK_HZ;
  localparam int unsigned CYC_SEC       = CLK_HZ;
  // One phase step of the VCXO output and the alignment window
  localparam int STEP_NS = 10;
  localparam int TOL_NS  = 10;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_PRESET  = 8'h08;
  localparam logic [7:0] A_SECONDS = 8'h0c;
  localparam logic [7:0] A_PHASE   = 8'h10;
  localparam logic [7:0] A_RESULT  = 8'h14;
  localparam logic [7:0] A_RBCTRL  = 8'h18;

  // CTRL fields
  localparam int B_PPS_EN = 0;
  localparam int B_F10_EN = 1;
  localparam int B_SET    = 2;
  // STATUS fields
  localparam int B_ST_LO  = 0;
  localparam int B_WARN   = 2;
  localparam int B_INHIB  = 3;
  localparam int B_LOCKED = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status indication codes
  localparam logic [1:0] ST_RED    = 2'h0;
  localparam logic [1:0] ST_YELLOW = 2'h1;
  localparam logic [1:0] ST_GREEN  = 2'h2;

  typedef enum logic [2:0] {
    AL_OFF, AL_JAM, AL_MEAS, AL_STEP, AL_LOCK
  } epa_align_t;

endpackage

// ---- bench/epa_ref_src.sv ----
`timescale 1ns/1ps
`default_nettype none

// ====
// Laboratory pulse and frequency reference sources
// ====
module epa_ref_src #(
  parameter int PERIOD_NS = 1600,
  parameter int WIDTH_NS  = 200
) (
  input  wire logic f10_on,
  output logic      external_second_pulse,
  output logic      freq_ref_present
);
  // Free running, offset so it never lines up with the bench clock
  initial begin
    external_second_pulse = 1'b0;
    #517;
    forever begin
      external_second_pulse = 1'b1;
      #(WIDTH_NS);
      external_second_pulse = 1'b0;
      #(PERIOD_NS - WIDTH_NS);
    end
  end

  // Frequency reference is optional: present only when plugged in
  assign freq_ref_present = f10_on;
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ====
  // Signals
  // ====
  logic               clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid, rv;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, gsec, rd;
  logic [1:0]         bresp, rresp, st, wb, rb;
  logic               ppsi, fpres, f10_on, nvp, nvf, pv, mv, gv;
  logic               ext10, tmv, fim, frz, jam, adv, ret, warn, inh, gu;
  logic               tc, t1k, ts, ind;
  logic signed [15:0] ph, rbc;
  logic signed [31:0] ms, mr, rms, res;
  int                 err_count, comparisons, i, c0, c1, c2;
  int                 n_jam, n_adv, n_ret, n_cal, n_1k, n_sec, n_res;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  epa_ref_src ref_src (.f10_on(f10_on), .external_second_pulse(ppsi),
    .freq_ref_present(fpres));

  // Short second and tick so alignment fits in a short run
  epa_align #(.CYC_SEC(40), .CYC_TICK(10)) uut (.clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_second_pulse(ppsi), .freq_ref_present(fpres),
    .nv_pps_en(nvp), .nv_f10_en(nvf), .phase_ns(ph), .phase_valid(pv),
    .meas_inst_src(ms), .meas_inst_ref(mr), .meas_valid(mv),
    .antenna_cal_ns(16'sh51), .gnss_seconds(gsec), .gnss_valid(gv),
    .vcxo_ref_ext10(ext10), .ten_mhz_from_vcxo(tmv),
    .freq_input_for_meas(fim), .rb_freeze(frz), .rb_ctrl(rbc),
    .jam_sync(jam), .phase_step_adv(adv), .phase_step_ret(ret),
    .tick_cal(tc), .tick_1k(t1k), .tick_sec(ts), .sec_tick_ind(ind),
    .status(st), .missing_freq_ref_warning(warn), .meas_inhibit(inh),
    .gnss_use(gu), .reference_minus_source(rms), .result_valid(rv));

  // Pulses are single cycle, so count them rather than poll them
  always @(posedge clk) begin
    n_jam <= n_jam + int'(jam);
    n_adv <= n_adv + int'(adv);
    n_ret <= n_ret + int'(ret);
    n_cal <= n_cal + int'(tc);
    n_1k  <= n_1k + int'(t1k);
    n_sec <= n_sec + int'(ts);
    n_res <= n_res + int'(rv);
    if (rv) res <= rms;
  end

  // ====
  // Tasks
  // ====
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic guard(input int k);
    if (k >= 99) begin
      err_count++;
      report_and_stop;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    wb = bresp;
    guard(k);
  endtask

  task automatic rdr(input logic [7:0] a);
    int k;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rb = rresp;
    guard(k);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask

  task automatic pulse(input logic signed [15:0] p,
                       input logic signed [31:0] s, input logic signed [31:0] r,
                       input logic m);
    @(posedge clk);
    ph <= p;
    ms <= s;
    mr <= r;
    pv <= ~m;
    mv <= m;
    @(posedge clk);
    pv <= 1'b0;
    mv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ====
  // Sequence
  // ====
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, pv, mv, gv, nvp} = '0;
    {awaddr, araddr, wdata, ph, ms, mr} = '0;
    {n_jam, n_adv, n_ret, n_cal, n_1k, n_sec, n_res} = '0;
    {err_count, comparisons} = '0;
    gsec   = 32'h99;
    f10_on = 1'b1;
    nvf    = 1'b1;
    nrst   = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(epa_pkg::A_CTRL, 32'h0);
    rchk(epa_pkg::A_STATUS, 32'h0);
    wr(epa_pkg::A_CTRL, 32'h2);
    rchk(epa_pkg::A_CTRL, 32'h0);
    chk({gu, ext10, fim}, 3'h5);
    pulse(16'sh0, 32'sh64, 32'sh1e, 1'b1);
    chk(res, 32'h97);
    $display("test select finished");

    wr(epa_pkg::A_CTRL, 32'h1);
    gv <= 1'b1;
    rchk(epa_pkg::A_STATUS, 32'h1);
    chk(gu, 1'b0);
    for (i = 0; i < 99 && n_jam == 0; i++) @(posedge clk);
    guard(i);
    chk(n_jam, 1);
    pulse(16'sha, 32'sh0, 32'sh0, 1'b0);
    chk(n_ret, 1);
    pulse(-16'sh19, 32'sh0, 32'sh0, 1'b0);
    chk(n_adv, 1);
    pulse(16'sh9, 32'sh0, 32'sh0, 1'b0);
    chk(n_ret + n_adv, 2);
    rchk(epa_pkg::A_STATUS, 32'h10);
    pulse(16'sh0, 32'sh64, 32'sh1e, 1'b1);
    chk(res, 32'h46);
    c0 = n_cal;
    c1 = n_1k;
    c2 = n_sec;
    repeat (120) @(posedge clk);
    chk(n_cal - c0, 24);
    chk(n_1k - c1, 12);
    chk(n_sec - c2, 3);
    // Phase is only taken in the last cycle of a second
    for (i = 0; i < 99 && !ts; i++) @(posedge clk);
    guard(i);
    repeat (37) @(posedge clk);
    pulse(16'sh3, 32'sh0, 32'sh0, 1'b0);
    rchk(epa_pkg::A_PHASE, 32'h3);
    rchk(epa_pkg::A_RBCTRL, 32'hfffffffd);
    chk({16'h0, rbc}, 32'hfffd);
    $display("test align finished");

    wr(epa_pkg::A_PRESET, 32'h1234);
    wr(epa_pkg::A_CTRL, 32'h5);
    // A tick in the arming cycle is counted before waiting
    @(posedge clk);
    c0 = n_sec;
    for (i = 0; i < 99 && n_sec == c0; i++) @(posedge clk);
    guard(i);
    chk(ind, 1'b1);
    repeat (4) @(posedge clk);
    rchk(epa_pkg::A_SECONDS, 32'h1234);
    rchk(epa_pkg::A_STATUS, 32'h12);
    repeat (20) @(posedge clk);
    chk(ind, 1'b0);
    $display("test set finished");

    wr(epa_pkg::A_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk({ext10, frz, tmv, fim}, 4'he);
    f10_on <= 1'b0;
    repeat (8) @(posedge clk);
    c0 = n_res;
    pulse(16'sh0, 32'sh64, 32'sh1e, 1'b1);
    chk({inh, warn, st}, 4'hc);
    chk(n_res - c0, 0);
    rdr(8'h1c);
    chk(rb, epa_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    wr(epa_pkg::A_SECONDS, 32'h1);
    chk(wb, epa_pkg::RESP_SLVERR);
    $display("test freq finished");

    nvp  <= 1'b1;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(epa_pkg::A_CTRL, 32'h3);
    $display("test restart finished");
    report_and_stop;
  end
endmodule

`default_nettype wire
